// ---- src/uhp_port.sv ----
// Host port control and status logic with the per-channel interrupt mask.
// Assumes a synchronous USB line interface in another clock domain whose
// line, connect, speed and wakeup levels are synchronised here.
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
module uhp_port #(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Line side levels, asynchronous to ref_clk
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic link_attached_in,
  input wire logic low_speed_in,
  input wire logic remote_wakeup_in,
  // Channel interrupt sources, same clock domain
  input wire logic [7:0] channel_irq_in,
  // Port drive outputs
  output logic port_reset_drive,
  output logic resume_drive,
  output logic port_sleep_request,
  output logic sof_enable,
  output logic power_claimed,
  // Global interrupt flags and interrupt line
  output logic host_port_irq_flag,
  output logic any_channel_irq_flag,
  output logic irq
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Mask and pending words are fixed at eight bits, so no other count fits.
  if (CHANNELS != 8)
  begin : g_bad_channels
    $error("CHANNELS must be 8 to fit the mask layout.");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic attached_d;
    logic [7:0] channel_irq_mask;
    logic [7:0] channel_irq_pending;
    logic port_reset_drive;
    logic port_sleep_request;
    logic resume_drive;
    logic power_claimed;
    logic port_enabled;
    logic enable_change_flag;
    logic connect_seen_flag;
    logic [1:0] attached_speed;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    uhp_pkg::uhp_bus_e bus;
    logic [31:0] readdata;
  } uhp_state_s;

  uhp_state_s st;
  uhp_state_s next_st;
  uhp_pkg::uhp_bus_req_s req;
  logic attached;
  logic wr_take;
  logic wr_port;
  logic wr_mask;
  logic wr_clear;
  logic wr_enable;
  logic disconnect;
  logic connect;
  logic wakeup;
  logic [7:0] masked;
  logic [31:0] port_word;

  // Bus request gathered into one carrier.
  assign req = '{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable};

  // Synchronised levels; only the second stage is read below.
  assign attached = st.sync_b[2];
  assign disconnect = st.attached_d & ~attached;
  assign connect = ~st.attached_d & attached;
  assign wakeup = st.sync_b[4];

  // Writes count only at the accepting cycle and only as whole words.
  assign wr_take = req.write & (st.bus == uhp_pkg::BUS_DONE) & (req.byteenable == 4'hf);
  assign wr_port = wr_take & (req.address == uhp_pkg::ADDR_HOST_PORT_CTRL);
  assign wr_mask = wr_take & (req.address == uhp_pkg::ADDR_CHANNEL_IRQ_MASK);
  assign wr_clear = wr_take & (req.address == uhp_pkg::ADDR_IRQ_CLEAR);
  assign wr_enable = wr_take & (req.address == uhp_pkg::ADDR_IRQ_ENABLE);

  // Per-channel gating of pending by mask.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
      assign masked[ch] = st.channel_irq_pending[ch] & st.channel_irq_mask[ch];
    end
  endgenerate

  // Readback image of the port register.
  always_comb
  begin
    port_word = uhp_pkg::RESET_WORD;
    port_word[uhp_pkg::POS_ATTACHED_NOW] = attached;
    port_word[uhp_pkg::POS_CONNECT_SEEN] = st.connect_seen_flag;
    port_word[uhp_pkg::POS_PORT_ENABLED] = st.port_enabled;
    port_word[uhp_pkg::POS_ENABLE_CHANGE] = st.enable_change_flag;
    port_word[uhp_pkg::POS_RESUME_DRIVE] = st.resume_drive;
    port_word[uhp_pkg::POS_SLEEP_REQUEST] = st.port_sleep_request;
    port_word[uhp_pkg::POS_RESET_DRIVE] = st.port_reset_drive;
    port_word[uhp_pkg::POS_LINE_DP] = st.sync_b[0];
    port_word[uhp_pkg::POS_LINE_DM] = st.sync_b[1];
    port_word[uhp_pkg::POS_POWER_CLAIMED] = st.power_claimed;
    port_word[uhp_pkg::POS_SPEED_LO +: 2] = st.attached_speed;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Hardware sets win over software clears in the same cycle, so no
  // event is lost while software is clearing its flag.
  always_comb
  begin
    next_st = st;
    next_st.sync_a = {remote_wakeup_in, low_speed_in, link_attached_in, line_dm, line_dp};
    next_st.sync_b = st.sync_a;
    next_st.attached_d = attached;
    next_st.attached_speed = !attached ? 2'h0 :
      (st.sync_b[3] ? uhp_pkg::SPEED_LOW : uhp_pkg::SPEED_FULL);
    next_st.channel_irq_pending = channel_irq_in;
    if (wr_mask)
    begin
      next_st.channel_irq_mask = req.writedata[7:0];
    end
    if (wr_port)
    begin
      next_st.port_reset_drive = req.writedata[uhp_pkg::POS_RESET_DRIVE];
      next_st.resume_drive = req.writedata[uhp_pkg::POS_RESUME_DRIVE];
      next_st.power_claimed = req.writedata[uhp_pkg::POS_POWER_CLAIMED];
      if (req.writedata[uhp_pkg::POS_SLEEP_REQUEST])
      begin
        next_st.port_sleep_request = 1'b1;
      end
      if (req.writedata[uhp_pkg::POS_PORT_ENABLED])
      begin
        next_st.port_enabled = 1'b0;
      end
      if (req.writedata[uhp_pkg::POS_ENABLE_CHANGE])
      begin
        next_st.enable_change_flag = 1'b0;
      end
      if (req.writedata[uhp_pkg::POS_CONNECT_SEEN])
      begin
        next_st.connect_seen_flag = 1'b0;
      end
    end
    // Suspend leaves only by these four causes; writing zero does nothing.
    if ((wr_port & (req.writedata[uhp_pkg::POS_RESET_DRIVE] |
        req.writedata[uhp_pkg::POS_RESUME_DRIVE])) | st.resume_drive | wakeup | disconnect)
    begin
      next_st.port_sleep_request = 1'b0;
    end
    // Enable sets at the end of reset signalling, clears on disconnect.
    if (st.port_reset_drive & ~next_st.port_reset_drive & attached)
    begin
      next_st.port_enabled = 1'b1;
    end
    if (disconnect)
    begin
      next_st.port_enabled = 1'b0;
    end
    if (next_st.port_enabled != st.port_enabled)
    begin
      next_st.enable_change_flag = 1'b1;
    end
    if (connect)
    begin
      next_st.connect_seen_flag = 1'b1;
    end
    // Sticky interrupt status, set wins over clear.
    if (wr_clear)
    begin
      next_st.irq_status = st.irq_status & ~req.writedata[1:0];
    end
    if (host_port_irq_flag)
    begin
      next_st.irq_status[uhp_pkg::IRQ_HOST_PORT] = 1'b1;
    end
    if (any_channel_irq_flag)
    begin
      next_st.irq_status[uhp_pkg::IRQ_ANY_CHANNEL] = 1'b1;
    end
    if (wr_enable)
    begin
      next_st.irq_enable = req.writedata[1:0];
    end
    // Bus: one wait cycle, then accept; read data is registered.
    next_st.bus = uhp_pkg::BUS_IDLE;
    next_st.readdata = st.readdata;
    if ((req.read | req.write) & (st.bus == uhp_pkg::BUS_IDLE))
    begin
      next_st.bus = uhp_pkg::BUS_DONE;
      case (req.address)
        uhp_pkg::ADDR_CHANNEL_IRQ_PENDING: next_st.readdata = {24'h0, st.channel_irq_pending};
        uhp_pkg::ADDR_CHANNEL_IRQ_MASK: next_st.readdata = {24'h0, st.channel_irq_mask};
        uhp_pkg::ADDR_HOST_PORT_CTRL: next_st.readdata = port_word;
        uhp_pkg::ADDR_IRQ_STATUS: next_st.readdata = {30'h0, st.irq_status};
        uhp_pkg::ADDR_IRQ_ENABLE: next_st.readdata = {30'h0, st.irq_enable};
        default: next_st.readdata = uhp_pkg::RESET_WORD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Synchronous reset to the documented zero state.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.bus <= uhp_pkg::BUS_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Port flag follows reset drive and the two hardware-set indications.
  assign host_port_irq_flag = st.port_reset_drive | st.enable_change_flag |
    st.connect_seen_flag;
  assign any_channel_irq_flag = |masked;
  assign irq = |(st.irq_status & st.irq_enable);
  assign port_reset_drive = st.port_reset_drive;
  assign resume_drive = st.resume_drive;
  assign port_sleep_request = st.port_sleep_request;
  assign sof_enable = st.port_enabled & ~st.port_sleep_request;
  assign power_claimed = st.power_claimed;
  assign avs_readdata = st.readdata;
  assign avs_waitrequest = (avs_read | avs_write) & (st.bus != uhp_pkg::BUS_DONE);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_mask_gates_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((st.channel_irq_pending & st.channel_irq_mask) == 8'h0) |-> !any_channel_irq_flag)
    else $error("Masked channel raised the any-channel flag.");
  a_any_channel_or: assert property (@(posedge ref_clk) disable iff (sys_rst)
    any_channel_irq_flag == |(st.channel_irq_pending & st.channel_irq_mask))
    else $error("Any-channel flag differs from pending and mask.");
  a_mask_write_lands: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_mask |=> st.channel_irq_mask == $past(avs_writedata[7:0]))
    else $error("Mask write did not land.");
  a_port_flag_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st.connect_seen_flag | st.enable_change_flag) |-> host_port_irq_flag)
    else $error("Port flag missing while an indication is set.");
  a_speed_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st.attached_speed != 2'h3)
    else $error("Reserved speed code reported.");
  a_enable_change_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st.port_enabled != $past(st.port_enabled)) |-> st.enable_change_flag)
    else $error("Enable toggled without change flag.");
  a_enable_not_sw: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(st.port_enabled) |-> $past(st.port_reset_drive) && !st.port_reset_drive)
    else $error("Port enable set without reset ending.");
  a_suspend_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st.port_sleep_request && !wr_port && !st.resume_drive && !wakeup && !disconnect)
    |=> st.port_sleep_request)
    else $error("Suspend cleared without cause.");
  a_sof_stop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st.port_sleep_request |-> !sof_enable)
    else $error("Frame starts during suspend.");
  a_disc_disable: assert property (@(posedge ref_clk) disable iff (sys_rst)
    disconnect |=> !st.port_enabled)
    else $error("Port stayed enabled after disconnect.");
  a_connect_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    connect |=> st.connect_seen_flag)
    else $error("Connection not flagged.");
  // Register effects one cycle after the accepting edge or the sampled cause. These watch stored state,
  // so a broken write decode shows even when no read follows the write.
  a_pending_copy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> st.channel_irq_pending == $past(channel_irq_in))
    else $error("Pending bits do not follow the channel sources.");
  a_reset_drive: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_port |=> port_reset_drive == $past(avs_writedata[uhp_pkg::POS_RESET_DRIVE]))
    else $error("Reset drive does not follow the written bit.");
  a_resume_drive: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_port |=> resume_drive == $past(avs_writedata[uhp_pkg::POS_RESUME_DRIVE]))
    else $error("Resume drive does not follow the written bit.");
  a_speed_detached: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !attached |=> st.attached_speed == 2'h0)
    else $error("Speed reported with no device attached.");
  a_port_status_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    host_port_irq_flag |=> st.irq_status[uhp_pkg::IRQ_HOST_PORT])
    else $error("Port flag did not reach the status register.");
  a_chan_status_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    any_channel_irq_flag |=> st.irq_status[uhp_pkg::IRQ_ANY_CHANNEL])
    else $error("Channel flag did not reach the status register.");
  a_enable_after_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_port && st.port_reset_drive && !avs_writedata[uhp_pkg::POS_RESET_DRIVE] && attached)
    |=> st.port_enabled)
    else $error("Port not enabled when reset signalling ended.");
  a_sw_disable: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_port && avs_writedata[uhp_pkg::POS_PORT_ENABLED] && !st.port_reset_drive)
    |=> !st.port_enabled)
    else $error("Port stayed enabled after a write of one.");
  a_connect_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_port && avs_writedata[uhp_pkg::POS_CONNECT_SEEN] && !connect) |=> !st.connect_seen_flag)
    else $error("Connect flag not cleared by a write of one.");
endmodule

// ---- src/uhp_pkg.sv ----
// Package for the host port control and channel interrupt mask block.
// Assumes a 32-bit Avalon-MM register bus and a single 100 MHz clock.
package uhp_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CHANNEL_IRQ_PENDING = 12'h414;
  localparam logic [11:0] ADDR_CHANNEL_IRQ_MASK = 12'h418;
  localparam logic [11:0] ADDR_HOST_PORT_CTRL = 12'h440;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h450;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h454;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h458;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [7:0] RESET_MASK = 8'h00;
  // ---------------------------------------------------------------
  // Port register field positions
  // ---------------------------------------------------------------
  localparam int POS_ATTACHED_NOW = 0;
  localparam int POS_CONNECT_SEEN = 1;
  localparam int POS_PORT_ENABLED = 2;
  localparam int POS_ENABLE_CHANGE = 3;
  localparam int POS_RESUME_DRIVE = 6;
  localparam int POS_SLEEP_REQUEST = 7;
  localparam int POS_RESET_DRIVE = 8;
  localparam int POS_LINE_DP = 10;
  localparam int POS_LINE_DM = 11;
  localparam int POS_POWER_CLAIMED = 12;
  localparam int POS_SPEED_LO = 17;
  localparam logic [1:0] SPEED_FULL = 2'h1;
  localparam logic [1:0] SPEED_LOW = 2'h2;
  // ---------------------------------------------------------------
  // Interrupt status bit positions
  // ---------------------------------------------------------------
  localparam int IRQ_HOST_PORT = 0;
  localparam int IRQ_ANY_CHANNEL = 1;
  localparam int IRQ_BITS = 2;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } uhp_bus_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } uhp_bus_rsp_s;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_DONE
  } uhp_bus_e;
endpackage

// ---- testbench/uhp_dev_model.sv ----
// Behavioural model of a device attached to the host port.
// Assumes the bench steers attach, speed and wakeup; lines have pull-downs.
`timescale 1ns/1ps
module uhp_dev_model (
  // Clock
  input wire logic ref_clk,
  // Bench steering
  input wire logic attach,
  input wire logic low_spd,
  input wire logic wake_req,
  // Host drive seen on the cable
  input wire logic port_reset_drive,
  input wire logic resume_drive,
  // Line levels towards the host
  output logic line_dp,
  output logic line_dm,
  output logic link_attached_in,
  output logic low_speed_in,
  output logic remote_wakeup_in
);
  // Line state follows host drive; detached lines fall to the pull-down level.
  always_comb
  begin
    link_attached_in = attach;
    low_speed_in = attach & low_spd;
    remote_wakeup_in = attach & wake_req;
    line_dp = ~low_spd;
    line_dm = low_spd;
    if (!attach)
    begin
      line_dp = 1'b0;
      line_dm = 1'b0;
    end
    else if (port_reset_drive)
    begin
      line_dp = 1'b0;
      line_dm = 1'b0;
    end
    else if (resume_drive)
    begin
      line_dp = low_spd;
      line_dm = ~low_spd;
    end
  end
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the host port and channel mask block.
// Assumes the package, the design and the device model are compiled first.
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] PORT = uhp_pkg::ADDR_HOST_PORT_CTRL;
  localparam logic [11:0] MASK = uhp_pkg::ADDR_CHANNEL_IRQ_MASK;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic line_dp, line_dm, link_attached_in, low_speed_in, remote_wakeup_in;
  logic [7:0] channel_irq_in = 8'h00;
  logic attach = 1'b0;
  logic low_spd = 1'b0;
  logic wake_req = 1'b0;
  logic port_reset_drive, resume_drive, port_sleep_request, sof_enable, power_claimed;
  logic host_port_irq_flag, any_channel_irq_flag, irq;
  int fail_count = 0;
  int n_checks = 0;

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  uhp_port i_uhp_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_dp(line_dp), .line_dm(line_dm),
    .link_attached_in(link_attached_in), .low_speed_in(low_speed_in),
    .remote_wakeup_in(remote_wakeup_in), .channel_irq_in(channel_irq_in),
    .port_reset_drive(port_reset_drive), .resume_drive(resume_drive),
    .port_sleep_request(port_sleep_request), .sof_enable(sof_enable),
    .power_claimed(power_claimed), .host_port_irq_flag(host_port_irq_flag),
    .any_channel_irq_flag(any_channel_irq_flag), .irq(irq));

  uhp_dev_model i_uhp_dev_model (.ref_clk(ref_clk), .attach(attach), .low_spd(low_spd),
    .wake_req(wake_req), .port_reset_drive(port_reset_drive), .resume_drive(resume_drive),
    .line_dp(line_dp), .line_dm(line_dm), .link_attached_in(link_attached_in),
    .low_speed_in(low_speed_in), .remote_wakeup_in(remote_wakeup_in));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One bus cycle; the request is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // The slave answers one wait cycle after the request, two edges in all.
    check("bus cycles", 32'h2, n);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
    wait_clk(2);
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(what, exp, q);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_mask();
    logic [31:0] q;
    rd("mask reset", MASK, 32'h0);
    rd("port reset", PORT, 32'h0);
    rd("unmapped", 12'h7fc, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      wr(MASK, 32'h1 << c);
      channel_irq_in <= ~(8'h01 << c);
      wait_clk(3);
      check("masked any", 32'h0, {31'h0, any_channel_irq_flag});
      channel_irq_in <= 8'h01 << c;
      wait_clk(3);
      check("unmasked any", 32'h1, {31'h0, any_channel_irq_flag});
      rd("pending", uhp_pkg::ADDR_CHANNEL_IRQ_PENDING, 32'h1 << c);
    end
    channel_irq_in <= 8'h00;
    wr(MASK, 32'ha5);
    bus(1'b1, MASK, 32'hff, 4'h1, q);
    rd("mask bits", MASK, 32'ha5);
  endtask

  task automatic t_port();
    attach <= 1'b1;
    wait_clk(8);
    rd("attach", PORT, 32'h0002_0403);
    check("hp flag set", 32'h1, {31'h0, host_port_irq_flag});
    wr(PORT, 32'h2);
    check("hp flag clr", 32'h0, {31'h0, host_port_irq_flag});
    wr(PORT, 32'h1100);
    check("reset drive", 32'h3, {30'h0, port_reset_drive, power_claimed});
    wait_clk(6);
    rd("in reset", PORT, 32'h0002_1101);
    check("hp flag rst", 32'h1, {31'h0, host_port_irq_flag});
    wr(PORT, 32'h1000);
    wait_clk(6);
    rd("enabled", PORT, 32'h0002_140d);
    check("sof on", 32'h1, {31'h0, sof_enable});
    wr(PORT, 32'h1008);
    wr(PORT, 32'h1004);
    rd("sw disable", PORT, 32'h0002_1409);
    wr(PORT, 32'h100c);
    rd("no sw enable", PORT, 32'h0002_1401);
    wr(PORT, 32'h1100);
    wr(PORT, 32'h1000);
    wr(PORT, 32'h1008);
    wait_clk(6);
    rd("re-enabled", PORT, 32'h0002_1405);
  endtask

  task automatic t_suspend();
    wr(PORT, 32'h1080);
    rd("suspend", PORT, 32'h0002_1485);
    check("sleep out", 32'h2, {30'h0, port_sleep_request, sof_enable});
    wr(PORT, 32'h1000);
    rd("zero kept", PORT, 32'h0002_1485);
    wake_req <= 1'b1;
    wait_clk(6);
    wake_req <= 1'b0;
    wait_clk(6);
    rd("wakeup", PORT, 32'h0002_1405);
    wr(PORT, 32'h1080);
    wr(PORT, 32'h1040);
    wait_clk(6);
    check("resume out", 32'h1, {31'h0, resume_drive});
    rd("resuming", PORT, 32'h0002_1845);
    wr(PORT, 32'h1000);
    wr(PORT, 32'h1080);
    wr(PORT, 32'h1100);
    check("rst wakes", 32'h0, {31'h0, port_sleep_request});
    wr(PORT, 32'h1000);
    wr(PORT, 32'h1080);
    attach <= 1'b0;
    wait_clk(8);
    rd("detach", PORT, 32'h0000_1008);
  endtask

  task automatic t_irq();
    wr(uhp_pkg::ADDR_IRQ_ENABLE, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq});
    rd("status", uhp_pkg::ADDR_IRQ_STATUS, 32'h3);
    wr(uhp_pkg::ADDR_IRQ_ENABLE, 32'h1);
    check("irq on", 32'h1, {31'h0, irq});
    wr(PORT, 32'h1008);
    rd("sticky", uhp_pkg::ADDR_IRQ_STATUS, 32'h3);
    wr(uhp_pkg::ADDR_IRQ_CLEAR, 32'h3);
    rd("cleared", uhp_pkg::ADDR_IRQ_STATUS, 32'h0);
    channel_irq_in <= 8'h01;
    wr(uhp_pkg::ADDR_IRQ_ENABLE, 32'h2);
    check("chan irq", 32'h1, {31'h0, irq});
    channel_irq_in <= 8'h00;
    wr(uhp_pkg::ADDR_IRQ_CLEAR, 32'h2);
    check("chan clr", 32'h0, {31'h0, irq});
    low_spd <= 1'b1;
    attach <= 1'b1;
    wait_clk(8);
    rd("low speed", PORT, 32'h0004_1803);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence: reset for three cycles, then the scenarios in order.
  initial
  begin
    wait_clk(3);
    sys_rst <= 1'b0;
    t_mask();
    t_port();
    t_suspend();
    t_irq();
    give_verdict();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial
  begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule
